// ==== logic/pin_routing_consts.vh ====
`ifndef PIN_ROUTING_CONSTS_VH
`define PIN_ROUTING_CONSTS_VH

// Byte addresses on the register bus
`define ROUTE_LOCK_OFS 12'h000
`define IN_SEL_BASE 12'h040
`define OUT_SEL_BASE 12'h100
`define ADDR_W 12

// Selector counts and field widths
`define IN_SEL_COUNT 12'h012
`define OUT_SEL_COUNT 12'h00c
`define IN_FIELD_W 6
`define OUT_FIELD_W 5
`define PIN_COUNT 12
`define SRC_COUNT 5'h1c

// Unlock key bytes
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa

// Lock register field
`define LOCKED_BIT 0

// Output selector reset value and port-latch code
`define OUT_SEL_RESET 5'h00
`define OUT_CODE_LATCH 5'h00

// Input pin code fields: port in bit 4, pin in bits 2:0
`define PIN_PORT_BIT 4
`define PINS_PER_PORT 4'h6

// Power-on default pin codes, selector 0 in the low six bits.
// Order: ext irq, timer0 clk, timer1 clk, timer1 gate, timer2 in,
// capture1, capture2, waveform in, cell in 0..3, adc trigger,
// serial clk, serial data, serial select, usart rx/data, usart clk.
`define IN_SEL_DEFAULTS { \
    6'h14, 6'h15, 6'h13, 6'h11, 6'h10, 6'h12, \
    6'h05, 6'h11, 6'h14, 6'h13, 6'h02, 6'h13, \
    6'h15, 6'h05, 6'h04, 6'h05, 6'h02, 6'h02 }

`endif

// ==== logic/peripheral_pin_routing.v ====
// Register map, one 32-bit word per register, byte addresses:
//   0x000        lock register, bit 0 is the locked flag
//   0x040..0x084 input selectors, one per peripheral input
//   0x100..0x12c output selectors, one per pin
//   elsewhere    reads zero, writes dropped, always OKAY
//
// Input selector order, index 0 first:
//   0  external interrupt
//   1  timer zero clock
//   2  timer one clock
//   3  timer one gate
//   4  timer two input
//   5  capture one
//   6  capture two
//   7  waveform generator input
//   8  logic cell input 0
//   9  logic cell input 1
//   10 logic cell input 2
//   11 logic cell input 3
//   12 converter trigger
//   13 serial clock
//   14 serial data
//   15 serial select
//   16 usart receive or data
//   17 usart clock
//
// Input pin codes: bit 4 picks port C, bits 2:0 the pin 0..5;
// codes with bit 5 or bit 3 set, or pin 6 or 7, read low.
//
// Output selector order: port A pins 0..5, then port C pins 0..5.
//
// Output source codes, bit k of the peripheral source bus:
//   0x1b reference clock, 0x1a oscillator, 0x19 timer zero
//   0x16 serial data, 0x15 serial clock
//   0x14 comparator two, 0x13 comparator one
//   0x10 usart sync data, 0x0f usart transmit or clock
//   0x0e..0x0b pulse width six..three
//   0x0a capture two, 0x09 capture one
//   0x08..0x05 waveform outputs d..a
//   0x04..0x01 logic cells four..one
//   0x00 port latch; 0x1c and up drive low
//
// Bus timing:
//   Writes end with no wait state; the selector or lock moves
//   at the edge that closes the data phase.
//   Reads insert one wait state and present data registered.
//   Routed inputs and pins follow one edge after a change.
//
// Lock flow:
//   Key bytes must be consecutive bus writes; a read between
//   them is harmless, any other write drops the partial key.
//   Under the one-way strap the first set after reset sticks
//   until the next reset of either kind.
//
// Hazard: no sleep input exists, so the selectors simply hold;
// a plain reset must never reach them or setups would be lost.
`include "pin_routing_consts.vh"

module peripheral_pin_routing (
    input wire mclk,
    input wire srst,
    input wire por,
    input wire one_way_lock_config,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    input wire [11:0] pin_in,
    input wire [11:0] port_latch,
    input wire [27:0] periph_src,
    output reg [17:0] periph_in,
    output reg [11:0] pin_out,
    output reg [11:0] pin_by_periph
);

    // Unlock key states, one-hot
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_HALF = 3'b010;
    localparam [2:0] ST_ARMED = 3'b100;

    // Power-on input defaults, selector 0 in the low six bits
    localparam [107:0] IN_DEFAULTS = `IN_SEL_DEFAULTS;

    // Pin code to pin level; unsupported codes read low
    function pick_pin;
        input [5:0] code;
        input [11:0] pins;
        reg [3:0] idx;
        begin
            idx = (code[`PIN_PORT_BIT] ? `PINS_PER_PORT : 4'h0) + {1'b0, code[2:0]};
            if (code[5] || code[3] || code[2:0] > 3'h5) begin
                pick_pin = 1'b0;
            end else begin
                pick_pin = pins[idx];
            end
        end
    endfunction

    // Region hit test, shared by the read and write decoders
    function in_region;
        input [11:0] addr;
        input [11:0] base;
        input [11:0] count;
        begin
            in_region = (addr >= base) && (addr < base + {count[9:0], 2'b00});
        end
    endfunction

    reg [5:0] in_sel_r [0:17];
    reg [4:0] out_sel_r [0:11];
    reg locked_r;
    reg perm_r;
    reg one_way_r;
    reg [2:0] key_r;
    reg [2:0] key_nxt;
    reg locked_nxt;
    reg perm_nxt;
    reg wr_pend_r;
    reg rd_pend_r;
    reg [11:0] addr_r;
    reg [31:0] rd_data;
    reg wr_pend_nxt;
    reg rd_pend_nxt;
    reg ready_nxt;
    reg [11:0] addr_nxt;
    reg [31:0] rdata_nxt;
    wire [17:0] in_pick;
    wire accept;
    wire any_reset;
    wire wr_lock;
    wire wr_in;
    wire wr_out;
    wire [4:0] in_idx;
    wire [3:0] out_idx;
    wire [11:0] in_off;
    wire [11:0] out_off;
    integer i;

    assign any_reset = srst | por;
    assign accept = hsel & htrans[1] & hready;
    assign in_off = addr_r - `IN_SEL_BASE;
    assign out_off = addr_r - `OUT_SEL_BASE;
    assign in_idx = in_off[6:2];
    assign out_idx = out_off[5:2];
    assign wr_lock = wr_pend_r && (addr_r == `ROUTE_LOCK_OFS);
    assign wr_in = wr_pend_r && in_region(addr_r, `IN_SEL_BASE, `IN_SEL_COUNT);
    assign wr_out = wr_pend_r && in_region(addr_r, `OUT_SEL_BASE, `OUT_SEL_COUNT);

    // Next values of the bus slave registers
    // Read data only moves in the wait cycle, so it stands until the next read
    always @* begin
        wr_pend_nxt = accept & hwrite;
        rd_pend_nxt = accept & ~hwrite;
        ready_nxt = ~(accept & ~hwrite);
        addr_nxt = addr_r;
        rdata_nxt = hrdata;
        if (accept) begin
            addr_nxt = haddr[11:0];
        end
        if (rd_pend_r) begin
            rdata_nxt = rd_data;
        end
    end

    // Bus slave: writes take no wait state, reads take one so that a read
    // right after a write sees the freshly written value
    always @(posedge mclk) begin
        if (any_reset) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            rd_pend_r <= rd_pend_nxt;
            hreadyout <= ready_nxt;
            hresp <= 1'b0;
            addr_r <= addr_nxt;
            hrdata <= rdata_nxt;
        end
    end

    // Read decoder; unmapped addresses read zero
    always @* begin
        rd_data = 32'h00000000;
        if (addr_r == `ROUTE_LOCK_OFS) begin
            rd_data = {31'h0, locked_r};
        end else if (in_region(addr_r, `IN_SEL_BASE, `IN_SEL_COUNT)) begin
            rd_data = {26'h0, in_sel_r[in_idx]};
        end else if (in_region(addr_r, `OUT_SEL_BASE, `OUT_SEL_COUNT)) begin
            rd_data = {27'h0, out_sel_r[out_idx]};
        end
    end

    // Key sequence and lock bit; software keeps the key writes uninterrupted
    always @* begin
        key_nxt = key_r;
        locked_nxt = locked_r;
        perm_nxt = perm_r;
        if (wr_pend_r && !wr_lock) begin
            key_nxt = ST_IDLE;
        end else if (wr_lock) begin
            case (key_r)
                ST_IDLE: begin
                    if (hwdata[7:0] == `KEY_FIRST) begin
                        key_nxt = ST_HALF;
                    end
                end
                ST_HALF: begin
                    if (hwdata[7:0] == `KEY_SECOND) begin
                        key_nxt = ST_ARMED;
                    end else if (hwdata[7:0] == `KEY_FIRST) begin
                        key_nxt = ST_HALF;
                    end else begin
                        key_nxt = ST_IDLE;
                    end
                end
                ST_ARMED: begin
                    key_nxt = ST_IDLE;
                    if (hwdata[`LOCKED_BIT]) begin
                        locked_nxt = 1'b1;
                        // Lock starts clear, so any set under one-way is the last
                        perm_nxt = perm_r | one_way_r;
                    end else if (!perm_r) begin
                        locked_nxt = 1'b0;
                    end
                end
                default: begin
                    key_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // Lock state follows every reset; permanent lock ends with any reset
    always @(posedge mclk) begin
        if (any_reset) begin
            key_r <= ST_IDLE;
            locked_r <= 1'b0;
            perm_r <= 1'b0;
        end else begin
            key_r <= key_nxt;
            locked_r <= locked_nxt;
            perm_r <= perm_nxt;
        end
    end

    // Configuration strap caught while reset is held
    always @(posedge mclk) begin
        if (any_reset) begin
            one_way_r <= one_way_lock_config;
        end
    end

    // Selectors: only power-on reset restores them; no sleep input touches them
    always @(posedge mclk) begin
        if (por) begin
            for (i = 0; i < `IN_SEL_COUNT; i = i + 1) begin
                in_sel_r[i] <= IN_DEFAULTS[i * `IN_FIELD_W +: 6];
            end
            for (i = 0; i < `OUT_SEL_COUNT; i = i + 1) begin
                out_sel_r[i] <= `OUT_SEL_RESET;
            end
        end else if (!locked_r) begin
            // Plain reset and sleep leave the values held
            if (wr_in) begin
                in_sel_r[in_idx] <= hwdata[5:0];
            end
            if (wr_out) begin
                out_sel_r[out_idx] <= hwdata[4:0];
            end
        end
    end

    // One routed input per peripheral function, each with its own selector
    genvar g;
    generate
        for (g = 0; g < `IN_SEL_COUNT; g = g + 1) begin : in_route
            // Pin level picked by this function's own selector
            assign in_pick[g] = pick_pin(in_sel_r[g], pin_in);
            always @(posedge mclk) begin
                if (any_reset) begin
                    periph_in[g] <= 1'b0;
                end else begin
                    periph_in[g] <= in_pick[g];
                end
            end
        end
        // Each pin picks a peripheral source; codes outside the table drive low
        for (g = 0; g < `OUT_SEL_COUNT; g = g + 1) begin : out_route
            always @(posedge mclk) begin
                if (any_reset) begin
                    pin_out[g] <= 1'b0;
                    pin_by_periph[g] <= 1'b0;
                end else if (out_sel_r[g] == `OUT_CODE_LATCH) begin
                    pin_out[g] <= port_latch[g];
                    pin_by_periph[g] <= 1'b0;
                end else if (out_sel_r[g] < `SRC_COUNT) begin
                    pin_out[g] <= periph_src[out_sel_r[g]];
                    pin_by_periph[g] <= 1'b1;
                end else begin
                    pin_out[g] <= 1'b0;
                    pin_by_periph[g] <= 1'b1;
                end
            end
        end
    endgenerate

endmodule

// ==== bench/periph_side_model.sv ====
module periph_side_model (
    input wire logic mclk,
    input wire logic step,
    output logic [11:0] pin_in,
    output logic [11:0] port_latch,
    output logic [27:0] periph_src
);
    timeunit 1ns;
    timeprecision 1ps;
    // Mixed start patterns so a stuck route cannot pass by luck
    initial begin
        pin_in = 12'ha5c;
        port_latch = 12'h3c6;
        periph_src = 28'h5a3c96e;
    end
    // Rotate only on request, so levels hold while a check looks
    always @(posedge mclk) begin
        if (step) begin
            pin_in <= {pin_in[10:0], pin_in[11]};
            port_latch <= {port_latch[10:0], port_latch[11]};
            periph_src <= {periph_src[26:0], periph_src[27]};
        end
    end
endmodule

// ==== bench/peripheral_pin_routing_checker.sv ====
module route_checker (
    input wire logic mclk,
    input wire logic srst,
    input wire logic por,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [11:0] port_latch,
    input wire logic [11:0] pin_out,
    input wire logic [11:0] pin_by_periph
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst || por);
    // Transfer accepted at this edge
    wire logic tk = hsel & htrans[1] & hready;
    sequence one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
    a_write_nowait: assert property (tk && hwrite |=> hreadyout) else $error("write stalled");
    a_read_wait: assert property (tk && !hwrite |=> one_wait) else $error("read wait wrong");
    a_wait_single: assert property (!hreadyout |=> hreadyout) else $error("long wait");
    a_rdata_hold: assert property ($past(hreadyout) |-> $stable(hrdata)) else $error("rdata moved");
    a_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("upper bits set");
    a_latch_pass: assert property (!$past(srst || por) |->
        ((pin_out ^ $past(port_latch)) & ~pin_by_periph) == 12'h0)
        else $error("latch not passed");
    a_por_clear: assert property ($fell(por) |-> (pin_by_periph == 12'h0) [*3])
        else $error("pin driven after por");
endmodule

bind peripheral_pin_routing route_checker chk_i (.mclk, .srst, .por, .hsel, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .hrdata, .port_latch, .pin_out, .pin_by_periph);

// ==== bench/peripheral_pin_routing_test.sv ====
`include "pin_routing_consts.vh"
module peripheral_pin_routing_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, srst = 1'b1, por = 1'b1, one_way_lock_config = 1'b0, step = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    wire hreadyout, hresp;
    wire [31:0] hrdata;
    wire [11:0] pin_in, port_latch, pin_out, pin_by_periph;
    wire [27:0] periph_src;
    wire [17:0] periph_in;
    int errors = 0, n_compared = 0;
    localparam logic [107:0] dflt = `IN_SEL_DEFAULTS;
    localparam logic [11:0] in0 = `IN_SEL_BASE;
    always #2.5 mclk = ~mclk;
    peripheral_pin_routing uut (.mclk(mclk), .srst(srst), .por(por),
        .one_way_lock_config(one_way_lock_config), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
        .port_latch(port_latch), .periph_src(periph_src), .periph_in(periph_in),
        .pin_out(pin_out), .pin_by_periph(pin_by_periph));
    periph_side_model far (.mclk(mclk), .step(step), .pin_in(pin_in),
        .port_latch(port_latch), .periph_src(periph_src));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Address phase held until ready, then data phase until ready
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask
    task key(input logic [31:0] v);
        wr(`ROUTE_LOCK_OFS, 32'h55);
        wr(`ROUTE_LOCK_OFS, 32'haa);
        wr(`ROUTE_LOCK_OFS, v);
    endtask
    // Move the far side, then let routing settle
    task tick;
        @(posedge mclk) step <= 1'b1;
        @(posedge mclk) step <= 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    task rst(input logic p);
        @(posedge mclk);
        srst <= ~p;
        por <= p;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        por <= 1'b0;
    endtask
    task t_reset_values;
        rchk(`ROUTE_LOCK_OFS, 32'h0);
        for (int i = 0; i < 18; i++) rchk(12'(in0 + 4 * i), 32'(dflt[6 * i +: 6]));
        for (int j = 0; j < 12; j++) rchk(12'(`OUT_SEL_BASE + 4 * j), 32'h0);
        wr(12'h3f0, 32'hff);
        rchk(12'h3f0, 32'h0);
    endtask
    task t_inputs;
        for (int i = 0; i < 18; i++) begin
            wr(12'(in0 + 4 * i), 32'({3'h6, i[0], 1'b0, 3'(i % 6)}));
            rchk(12'(in0 + 4 * i), 32'({i[0], 1'b0, 3'(i % 6)}));
            tick;
            chk(periph_in[i], pin_in[6 * i[0] + i % 6]);
        end
    endtask
    task t_outputs;
        for (int k = 1; k < 28; k++) begin
            wr(12'(`OUT_SEL_BASE + 4 * (k % 12)), 32'(8'he0 | k));
            rchk(12'(`OUT_SEL_BASE + 4 * (k % 12)), 32'(k));
            tick;
            chk(pin_out[k % 12], periph_src[k]);
            chk(pin_by_periph[k % 12], 1'b1);
        end
        wr(12'(`OUT_SEL_BASE + 4), 32'h1f);
        tick;
        chk(pin_out[1], 1'b0);
        chk(pin_by_periph[1], 1'b1);
        wr(`OUT_SEL_BASE, 32'h0);
        tick;
        chk(pin_out[0], port_latch[0]);
        chk(pin_by_periph[0], 1'b0);
    endtask
    task t_lock;
        key(32'h1);
        rchk(`ROUTE_LOCK_OFS, 32'h1);
        wr(in0, 32'h05);
        rchk(in0, 32'h0);
        wr(`ROUTE_LOCK_OFS, 32'h0);
        rchk(`ROUTE_LOCK_OFS, 32'h1);
        wr(`ROUTE_LOCK_OFS, 32'h55);
        wr(in0, 32'h05);
        wr(`ROUTE_LOCK_OFS, 32'haa);
        wr(`ROUTE_LOCK_OFS, 32'h0);
        rchk(`ROUTE_LOCK_OFS, 32'h1);
        wr(`ROUTE_LOCK_OFS, 32'h55);
        rchk(in0, 32'h0);
        wr(`ROUTE_LOCK_OFS, 32'haa);
        wr(`ROUTE_LOCK_OFS, 32'h0);
        rchk(`ROUTE_LOCK_OFS, 32'h0);
        wr(in0, 32'h05);
        rchk(in0, 32'h05);
    endtask
    task t_one_way;
        one_way_lock_config <= 1'b1;
        rst(1'b0);
        rchk(in0, 32'h05);
        key(32'h0);
        key(32'h1);
        key(32'h0);
        rchk(`ROUTE_LOCK_OFS, 32'h1);
        wr(in0, 32'h03);
        rchk(in0, 32'h05);
        rst(1'b1);
        rchk(`ROUTE_LOCK_OFS, 32'h0);
        rchk(in0, 32'(dflt[5:0]));
        rchk(12'(`OUT_SEL_BASE + 12), 32'h0);
        wr(in0, 32'h03);
        rchk(in0, 32'h03);
        one_way_lock_config <= 1'b0;
    endtask
    task tally_and_finish;
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence after the opening reset
    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        por <= 1'b0;
        t_reset_values;
        t_inputs;
        t_outputs;
        t_lock;
        t_one_way;
        tally_and_finish;
    end
    // Hang guard, several times the expected run length
    initial begin
        #50000;
        errors++;
        tally_and_finish;
    end
endmodule
